// [rtl/bst_defines.vh]
// Purpose: constants for the boundary-scan test port
// Assumes: included by bst_tap.v and by the testbench
// Notes:   instruction codes are two bits wide
`ifndef BST_DEFINES_VH
`define BST_DEFINES_VH

// ----------------------------------------
// instruction register
// ----------------------------------------
`define BST_IR_W        2
`define BST_IR_EXTEST   2'h0
`define BST_IR_SAMPLE   2'h1
`define BST_IR_IDCODE   2'h2
`define BST_IR_BYPASS   2'h3
// capture value of the instruction register, low bits 01 as usual
`define BST_IR_CAPTURE  2'h1

// ----------------------------------------
// identification
// ----------------------------------------
// arbitrary value, bit 0 must be one
`define BST_IDCODE      32'h1234_5001

// ----------------------------------------
// three-level select encoding
// ----------------------------------------
`define BST_LVL_LOW     2'h0
`define BST_LVL_MID     2'h1
`define BST_LVL_HIGH    2'h2
`define BST_SCAN_LOW    2'h0
`define BST_SCAN_MID    2'h2
`define BST_SCAN_HIGH   2'h3

`endif

// [rtl/bst_tap.v]
// Purpose: boundary-scan test access port with boundary and bypass paths
// Assumes: test pins are synchronous to core_clk_i and test_clock toggles well below its rate
// Notes:   test clock edges are found by sampling, so no second clock domain exists
//
// Operation
// - only boundary scan and bypass test paths; identification read as well.
// - scan cells on parallel pins, training clock and reference clock inputs.
// - serial line pins carry no scan cells at all.
// - test reset pin low forces the controller to its reset state.
// - test mode select high for five test clocks reaches reset state.
// - in reset state the functional pins pass through untouched.
// - functional reset and test reset work in either order.
// - three-level select scans as 00 low, 10 mid, 11 high.
// - a fixed identification code is readable over the test data path.
`timescale 1ns/1ns
`include "bst_defines.vh"

module bst_tap #(
    parameter N_IN  = 16,
    parameter N_OUT = 16,
    parameter N_SEL = 4
) (
    // clock, reset, enable
    input  wire                 core_clk_i,
    input  wire                 reset_i,
    input  wire                 clk_en_i,
    // test port pins
    input  wire                 test_clock_i,
    input  wire                 test_mode_sel_i,
    input  wire                 test_data_i,
    input  wire                 test_reset_n_i,
    output reg                  test_data_o,
    output reg                  test_data_oe_o,
    // functional pins seen by the chain
    input  wire [N_IN-1:0]      par_in_i,
    input  wire                 training_clock_input_i,
    input  wire                 transmit_reference_clock_input_i,
    input  wire [2*N_SEL-1:0]   sel_level_i,
    input  wire [N_OUT-1:0]     core_out_i,
    output reg  [N_OUT-1:0]     par_out_o
);

    // ----------------------------------------
    // controller states
    // ----------------------------------------
    localparam [3:0] S_TLR = 4'h0, S_RTI = 4'h1, S_SDR = 4'h2, S_CDR = 4'h3,
                     S_SHD = 4'h4, S_E1D = 4'h5, S_PSD = 4'h6, S_E2D = 4'h7,
                     S_UDR = 4'h8, S_SIR = 4'h9, S_CIR = 4'ha, S_SHI = 4'hb,
                     S_E1I = 4'hc, S_PSI = 4'hd, S_E2I = 4'he, S_UIR = 4'hf;
    // serial line pins are deliberately absent from this sum
    localparam CHAIN = N_OUT + 2 * N_SEL + 2 + N_IN;

    reg  [3:0]              state_q;
    reg  [3:0]              state_d;
    reg                     tck_q;
    reg  [`BST_IR_W-1:0]    ir_sh_q;
    reg  [`BST_IR_W-1:0]    ir_q;
    reg  [CHAIN-1:0]        bs_sh_q;
    reg  [N_OUT-1:0]        bs_upd_q;
    reg  [31:0]             id_sh_q;
    reg                     byp_q;
    wire                    tck_rise;
    wire                    tck_fall;
    wire [2*N_SEL-1:0]      sel_scan;
    wire [CHAIN-1:0]        bs_cap;
    wire                    extest;

    assign tck_rise = clk_en_i & test_clock_i & ~tck_q;
    assign tck_fall = clk_en_i & ~test_clock_i & tck_q;
    assign extest   = (ir_q == `BST_IR_EXTEST);

    // ----------------------------------------
    // controller decodes
    // ----------------------------------------
    // instruction reset on entry, so pins are released as soon as reset state is reached
    wire                    enter_tlr;
    wire                    cap_dr;
    wire                    sh_dr;
    wire                    upd_bs;
    wire                    cap_ir;
    wire                    sh_ir;
    wire                    upd_ir;
    reg                     tdo_d;

    assign enter_tlr = (state_d == S_TLR);
    assign cap_dr    = (state_q == S_CDR);
    assign sh_dr     = (state_q == S_SHD);
    assign upd_bs    = (state_q == S_UDR) && (extest || ir_q == `BST_IR_SAMPLE);
    assign cap_ir    = (state_q == S_CIR);
    assign sh_ir     = (state_q == S_SHI);
    assign upd_ir    = (state_q == S_UIR);

    // ----------------------------------------
    // three-level select encoding
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < N_SEL; g = g + 1) begin : g_sel
            assign sel_scan[2*g+1:2*g] =
                (sel_level_i[2*g+1:2*g] == `BST_LVL_HIGH) ? `BST_SCAN_HIGH :
                (sel_level_i[2*g+1:2*g] == `BST_LVL_MID)  ? `BST_SCAN_MID  :
                                                             `BST_SCAN_LOW;
        end
    endgenerate

    // bit 0 sits nearest the data output
    assign bs_cap = {core_out_i, sel_scan, transmit_reference_clock_input_i,
                     training_clock_input_i, par_in_i};

    // ----------------------------------------
    // controller next state
    // ----------------------------------------
    always @* begin
        case (state_q)
            S_TLR:   state_d = test_mode_sel_i ? S_TLR : S_RTI;
            S_RTI:   state_d = test_mode_sel_i ? S_SDR : S_RTI;
            S_SDR:   state_d = test_mode_sel_i ? S_SIR : S_CDR;
            S_CDR:   state_d = test_mode_sel_i ? S_E1D : S_SHD;
            S_SHD:   state_d = test_mode_sel_i ? S_E1D : S_SHD;
            S_E1D:   state_d = test_mode_sel_i ? S_UDR : S_PSD;
            S_PSD:   state_d = test_mode_sel_i ? S_E2D : S_PSD;
            S_E2D:   state_d = test_mode_sel_i ? S_UDR : S_SHD;
            S_UDR:   state_d = test_mode_sel_i ? S_SDR : S_RTI;
            S_SIR:   state_d = test_mode_sel_i ? S_TLR : S_CIR;
            S_CIR:   state_d = test_mode_sel_i ? S_E1I : S_SHI;
            S_SHI:   state_d = test_mode_sel_i ? S_E1I : S_SHI;
            S_E1I:   state_d = test_mode_sel_i ? S_UIR : S_PSI;
            S_PSI:   state_d = test_mode_sel_i ? S_E2I : S_PSI;
            S_E2I:   state_d = test_mode_sel_i ? S_UIR : S_SHI;
            S_UIR:   state_d = test_mode_sel_i ? S_SDR : S_RTI;
            default: state_d = S_TLR;
        endcase
    end

    // ----------------------------------------
    // controller and instruction
    // ----------------------------------------
    // functional reset also parks the controller, so either reset order ends alike
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            tck_q   <= 1'b0;
            state_q <= S_TLR;
            ir_sh_q <= `BST_IR_CAPTURE;
            ir_q    <= `BST_IR_IDCODE;
        end else if (clk_en_i) begin
            tck_q <= test_clock_i;
            if (!test_reset_n_i) begin
                state_q <= S_TLR;
                ir_q    <= `BST_IR_IDCODE;
            end else if (tck_rise) begin
                state_q <= state_d;
                if (enter_tlr)
                    ir_q <= `BST_IR_IDCODE;
                if (cap_ir)
                    ir_sh_q <= `BST_IR_CAPTURE;
                else if (sh_ir)
                    ir_sh_q <= {test_data_i, ir_sh_q[`BST_IR_W-1:1]};
                if (upd_ir)
                    ir_q <= ir_sh_q;
            end
        end
    end

    // ----------------------------------------
    // data registers
    // ----------------------------------------
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            bs_sh_q  <= {CHAIN{1'b0}};
            bs_upd_q <= {N_OUT{1'b0}};
            id_sh_q  <= 32'h0000_0000;
            byp_q    <= 1'b0;
        end else if (tck_rise && test_reset_n_i) begin
            if (cap_dr) begin
                bs_sh_q <= bs_cap;
                id_sh_q <= `BST_IDCODE;
                byp_q   <= 1'b0;
            end else if (sh_dr) begin
                bs_sh_q <= {test_data_i, bs_sh_q[CHAIN-1:1]};
                id_sh_q <= {test_data_i, id_sh_q[31:1]};
                byp_q   <= test_data_i;
            end
            // sample/preload may load the update stage too
            if (upd_bs)
                bs_upd_q <= bs_sh_q[CHAIN-1:CHAIN-N_OUT];
        end
    end

    // ----------------------------------------
    // test data out select
    // ----------------------------------------
    // instruction shift path overrides the selected data register
    always @* begin
        case (ir_q)
            `BST_IR_BYPASS: tdo_d = byp_q;
            `BST_IR_IDCODE: tdo_d = id_sh_q[0];
            default:        tdo_d = bs_sh_q[0];
        endcase
        if (sh_ir)
            tdo_d = ir_sh_q[0];
    end

    // ----------------------------------------
    // data output and pins
    // ----------------------------------------
    // output changes on the falling test clock, as a tester expects
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            test_data_o    <= 1'b0;
            test_data_oe_o <= 1'b0;
            par_out_o      <= {N_OUT{1'b0}};
        end else if (clk_en_i) begin
            // one cycle of delay on functional outputs, traded for glitch-free pins
            par_out_o <= extest ? bs_upd_q : core_out_i;
            if (tck_fall) begin
                test_data_oe_o <= sh_dr || sh_ir;
                test_data_o    <= tdo_d;
            end
        end
    end

endmodule

// [tb/bst_jtag_ctrl.sv]
// Purpose: board test controller model
// Assumes: three or four core cycles per test clock phase
// Notes:   test clock stands low between bits
`timescale 1ns/1ns
module bst_jtag_ctrl (
    input  wire core_clk_i,
    input  wire tdo_i,
    output reg  tck_o,
    output reg  tms_o,
    output reg  tdi_o,
    output reg  trst_n_o
);
    initial begin
        tck_o = 1'h0;
        tms_o = 1'h1;
        tdi_o = 1'h0;
        trst_n_o = 1'h1;
    end
    task automatic pulse(input logic ms, input logic di, output logic dout);
        @(posedge core_clk_i) #1 tms_o = ms;
        tdi_o = di;
        repeat (3) @(posedge core_clk_i);
        #1 tck_o = 1'h1;
        dout = tdo_i;
        // data in must stand through the high phase, the port takes it a cycle after the rise
        repeat (3) @(posedge core_clk_i);
        #1 tck_o = 1'h0;
    endtask
    task automatic reset_tap(input logic by_pin);
        logic b;
        if (by_pin) begin
            @(posedge core_clk_i) #1 trst_n_o = 1'h0;
            repeat (2) @(posedge core_clk_i);
            #1 trst_n_o = 1'h1;
        end else
            repeat (5) pulse(1'h1, 1'h0, b);
        pulse(1'h0, 1'h0, b);
    endtask
    // from idle: shift n bits, update, back to idle
    task automatic scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout);
        logic b;
        dout = '0;
        pulse(1'h1, 1'h0, b);
        if (ir)
            pulse(1'h1, 1'h0, b);
        pulse(1'h0, 1'h0, b);
        pulse(1'h0, 1'h0, b);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], b);
            dout[i] = b;
        end
        pulse(1'h1, 1'h0, b);
        pulse(1'h0, 1'h0, b);
    endtask
endmodule

// [tb/bst_tap_asserts.sv]
// Purpose: port-level checks of the test port
// Assumes: test clock phases last at least two core cycles
// Notes:   test clock edges are rebuilt here from samples
`timescale 1ns/1ns
module bst_tap_asserts #(
    parameter N_OUT = 16
) (
    input wire             core_clk_i,
    input wire             reset_i,
    input wire             test_clock_i,
    input wire             test_mode_sel_i,
    input wire             test_reset_n_i,
    input wire             test_data_o,
    input wire             test_data_oe_o,
    input wire [N_OUT-1:0] core_out_i,
    input wire [N_OUT-1:0] par_out_o
);
    logic       tck_q;
    logic [2:0] hi_q;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // saturating count of test clock rises with mode select high
    always @(posedge core_clk_i) begin
        tck_q <= reset_i ? 1'h0 : test_clock_i;
        if (reset_i)
            hi_q <= 3'h0;
        else if (test_clock_i && !tck_q)
            hi_q <= !test_mode_sel_i ? 3'h0 : (hi_q == 3'h5 ? hi_q : hi_q + 3'h1);
    end
    sequence s_trst; !test_reset_n_i ##1 !test_reset_n_i; endsequence
    sequence s_fall; $past(test_clock_i, 2) && !$past(test_clock_i); endsequence
    property p_clear; $fell(reset_i) |-> !test_data_o && !test_data_oe_o && par_out_o == '0; endproperty
    property p_quiet; $fell(reset_i) |-> !test_data_oe_o[*8]; endproperty
    property p_pass; $fell(reset_i) |=> par_out_o == $past(core_out_i); endproperty
    property p_edge; ($changed(test_data_o) || $changed(test_data_oe_o)) && !$past(reset_i) |-> s_fall; endproperty
    property p_hold; $changed(test_data_o) |=> $stable(test_data_o)[*3]; endproperty
    property p_trst; s_trst |=> par_out_o == $past(core_out_i); endproperty
    property p_oe; $rose(test_data_oe_o) |-> $past(test_reset_n_i, 2) && $past(test_reset_n_i, 3); endproperty
    property p_tms5; $rose(hi_q == 3'h5) |-> ##3 par_out_o == $past(core_out_i); endproperty
    a_clear: assert property (p_clear) else $error("outputs not cleared by reset");
    a_quiet: assert property (p_quiet) else $error("shift enable right after reset");
    a_pass: assert property (p_pass) else $error("pins not passed after reset");
    a_edge: assert property (p_edge) else $error("data out moved off a test clock fall");
    a_hold: assert property (p_hold) else $error("data out not held");
    a_trst: assert property (p_trst) else $error("pins not passed in reset state");
    a_oe: assert property (p_oe) else $error("shift enable during test reset");
    a_tms5: assert property (p_tms5) else $error("mode select reset missed");
endmodule
bind bst_tap bst_tap_asserts #(.N_OUT(N_OUT)) u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .test_clock_i(test_clock_i), .test_mode_sel_i(test_mode_sel_i), .test_reset_n_i(test_reset_n_i),
    .test_data_o(test_data_o), .test_data_oe_o(test_data_oe_o), .core_out_i(core_out_i), .par_out_o(par_out_o));

// [tb/testbench.sv]
// Purpose: self-checking bench for the test port
// Assumes: 16-cell chain from 4 inputs, 3 selects, 4 outputs
// Notes:   small chain keeps the scans short
`timescale 1ns/1ns
`include "bst_defines.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module testbench;
    logic        clk, rst, tck, tms, tdi, trst_n, tdo, oe, trn, refc, en;
    logic [3:0]  par_in, cout, pout;
    logic [5:0]  sel;
    logic [63:0] d;
    int          bad_count, comparisons;
    wire         tdo_w = oe ? tdo : ~tdo;
    bst_tap #(.N_IN(4), .N_OUT(4), .N_SEL(3)) uut (.core_clk_i(clk), .reset_i(rst), .clk_en_i(en),
        .test_clock_i(tck), .test_mode_sel_i(tms), .test_data_i(tdi), .test_reset_n_i(trst_n),
        .test_data_o(tdo), .test_data_oe_o(oe), .par_in_i(par_in), .training_clock_input_i(trn),
        .transmit_reference_clock_input_i(refc), .sel_level_i(sel), .core_out_i(cout), .par_out_o(pout));
    bst_jtag_ctrl c (.core_clk_i(clk), .tdo_i(tdo_w), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n));
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic t_idcode();
        logic b;
        c.reset_tap(1'h1);
        // a test clock pulse while frozen must not move the controller
        @(posedge clk) #1 en = 1'h0;
        c.pulse(1'h1, 1'h0, b);
        @(posedge clk) #1 en = 1'h1;
        c.scan(1'h0, 64'h0, 32, d);
        `CHK(d[31:0], `BST_IDCODE)
    endtask
    task automatic t_bypass();
        c.scan(1'h1, 64'h3, 2, d);
        `CHK(d[1:0], `BST_IR_CAPTURE)
        c.scan(1'h0, 64'h5a, 8, d);
        `CHK(d[7:0], 8'hb4)
    endtask
    task automatic t_sample();
        @(posedge clk) #1 par_in = 4'h9;
        trn = 1'h1;
        sel = 6'h24;
        c.scan(1'h1, 64'h1, 2, d);
        c.scan(1'h0, 64'h5000a, 20, d);
        `CHK(d[15:0], {4'h6, 6'h38, 1'h0, 1'h1, 4'h9})
        `CHK(d[19:16], 4'ha)
    endtask
    task automatic t_extest(input int how);
        logic b;
        c.scan(1'h1, 64'h0, 2, d);
        `CHK(pout, 4'h5)
        if (how == 2) begin
            @(posedge clk) #1 rst = 1'h1;
            @(posedge clk) #1 rst = 1'h0;
            c.pulse(1'h0, 1'h0, b);
        end else
            c.reset_tap(how == 1);
        repeat (3) @(posedge clk);
        `CHK(pout, 4'h6)
    endtask
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        bad_count++;
        results();
    end
    initial begin
        {rst, par_in, trn, refc, sel, cout} = {1'h1, 4'h0, 1'h0, 1'h0, 6'h0, 4'h6};
        en = 1'h1;
        repeat (20) @(posedge clk);
        #1 rst = 1'h0;
        t_idcode();
        t_bypass();
        for (int m = 0; m < 3; m++) begin
            t_sample();
            t_extest(m);
        end
        results();
    end
endmodule
